// [pors_pkg.sv]
package pors_pkg;

   // ************************************
   // timing
   // ************************************
   localparam int CLOCK_HZ            = 25000000;
   localparam int DELAY_LOW_US        = 7000;
   localparam int DELAY_HIGH_US       = 15000;
   localparam int DELAY_LOW_CYCLES    = DELAY_LOW_US * (CLOCK_HZ / 1000000);
   localparam int DELAY_HIGH_CYCLES   = DELAY_HIGH_US * (CLOCK_HZ / 1000000);
   localparam int WDOG_DIVIDE         = 12;
   localparam int DIV_W               = 4;

   // ************************************
   // reset values
   // ************************************
   localparam logic [7:0]  PORT_LATCH_RESET = 8'hFF;
   localparam logic [15:0] RESET_VECTOR     = 16'h0000;
   localparam int          POR_MON_OFF_BIT  = 5;

   typedef enum logic [1:0] {
      ST_RESET = 2'h0,
      ST_DELAY = 2'h1,
      ST_RUN   = 2'h3
   } pors_state_type;

   typedef struct packed {
      logic supplyLow;
      logic monitorLow;
      logic pinReset;
      logic softReset;
      logic otherReset;
   } pors_req_type;

   typedef struct packed {
      logic        cpuHalt;
      logic        sfrInit;
      logic        portsForce;
      logic        irqTimerOff;
      logic        pullupsOn;
      logic [7:0]  portLatch;
      logic [15:0] pcValue;
      logic        clockSelInternal;
      logic        wdogEnable;
   } pors_ctl_type;

endpackage

// [pors_sequencer.sv]
// Functional notes
// - reset halts cpu, inits registers, forces ports, disables interrupts and timers.
// - ram untouched by reset; stack pointer reset only.
// - port latches 0xFF open-drain during reset; pull-ups always on.
// - supply-monitor and power-on resets drive reset pin low until exit.
// - exit clears program counter and selects internal oscillator.
// - watchdog enabled after reset, clocked by system clock over 12.
// - fetch starts at 0x0000 after every reset.
// - stay in reset during power-up; pin weakly pulled.
// - after threshold, wait 7 ms low supply or 15 ms high supply.
// - leaving power-on reset sets power-on flag.
// - other resets clear power-on flag; other causes then undefined.
// - power-on monitor watches battery in sleep and resets below threshold.
// - writing 1 to mode bit 5 disables power-on monitor.
// - monitor disabled: any reset becomes full power-on reset, re-enabling it.
// - active supply monitor reset skips power-on delay.
// - after power-fail reset flag reads 1, digital monitor enabled and selected.
module pors_sequencer #(
   parameter int DELAY_LOW  = pors_pkg::DELAY_LOW_CYCLES,
   parameter int DELAY_HIGH = pors_pkg::DELAY_HIGH_CYCLES
) (
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  nrst,
   input  wire logic                  clockEnable,
   // reset requests
   input  wire pors_pkg::pors_req_type resetReq,
   input  wire logic                  highSupply,
   // power unit mode register write
   input  wire logic                  modeWrite,
   input  wire logic [7:0]            modeData,
   // outputs
   output pors_pkg::pors_ctl_type     ctl,
   output logic                       coreReset,
   output logic                       resetPinLow,
   output logic                       resetPinOe,
   output logic                       powerOnFlag,
   output logic                       porMonitorOn,
   output logic                       digitalMonitorOn,
   output logic                       wdogTick
);

   if (DELAY_LOW < 1 || DELAY_HIGH < DELAY_LOW || DELAY_HIGH > 32'h00FFFFFF)
   begin : g_badDelay
      $error("bad delay parameters");
   end

   // ************************************
   // synchronisers
   // ************************************
   logic       rstMeta_reg, rstSync_reg;
   logic [4:0] reqMeta_reg, reqSync_reg;
   logic [1:0] hiMeta_reg;

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end
      else
      begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end

   always_ff @(posedge clock)
   begin
      if (clockEnable)
      begin
         reqMeta_reg <= resetReq;
         reqSync_reg <= reqMeta_reg;
         hiMeta_reg  <= {hiMeta_reg[0], highSupply};
      end
   end

   wire pors_pkg::pors_req_type req = reqSync_reg;
   wire anyReq = |reqSync_reg;

   // ************************************
   // sequencer
   // ************************************
   pors_pkg::pors_state_type state_reg;
   logic [23:0] count_reg;
   logic        porCycle_reg;
   logic        por_monitor_disable_reg;
   logic        monCycle_reg;

   wire monDisWrite = modeWrite && modeData[pors_pkg::POR_MON_OFF_BIT];
   wire [23:0] delayTarget = hiMeta_reg[1] ? 24'(DELAY_HIGH) : 24'(DELAY_LOW);

   always_ff @(posedge clock or negedge rstSync_reg)
   begin
      if (!rstSync_reg)
      begin
         state_reg    <= pors_pkg::ST_RESET;
         count_reg    <= 24'h000000;
         porCycle_reg <= 1'b1;
         por_monitor_disable_reg   <= 1'b0;
         monCycle_reg <= 1'b0;
      end
      else if (clockEnable)
      begin
         case (state_reg)
            pors_pkg::ST_RUN:
            begin
               if (monDisWrite && !anyReq)
                  por_monitor_disable_reg <= 1'b1;
               if (req.supplyLow || (anyReq && por_monitor_disable_reg))
               begin
                  state_reg    <= pors_pkg::ST_RESET;
                  porCycle_reg <= 1'b1;
                  monCycle_reg <= 1'b0;
                  por_monitor_disable_reg   <= 1'b0;
               end
               else if (anyReq)
               begin
                  state_reg    <= pors_pkg::ST_RESET;
                  porCycle_reg <= 1'b0;
                  monCycle_reg <= req.monitorLow;
               end
            end
            pors_pkg::ST_RESET:
            begin
               count_reg <= 24'h000000;
               if (req.supplyLow)
                  porCycle_reg <= 1'b1;
               if (req.monitorLow)
                  monCycle_reg <= 1'b1;
               if (!anyReq)
                  state_reg <= porCycle_reg ? pors_pkg::ST_DELAY
                                            : pors_pkg::ST_RUN;
            end
            default:
            begin
               if (anyReq)
                  state_reg <= pors_pkg::ST_RESET;
               else if (count_reg >= delayTarget - 24'h000001)
                  state_reg <= pors_pkg::ST_RUN;
               else
                  count_reg <= count_reg + 24'h000001;
            end
         endcase
      end
   end

   wire inReset = (state_reg != pors_pkg::ST_RUN);

   // ************************************
   // flags and outputs
   // ************************************
   always_ff @(posedge clock or negedge rstSync_reg)
   begin
      if (!rstSync_reg)
      begin
         powerOnFlag      <= 1'b0;
         digitalMonitorOn <= 1'b1;
      end
      else if (clockEnable && state_reg == pors_pkg::ST_DELAY && !anyReq
               && count_reg >= delayTarget - 24'h000001)
      begin
         powerOnFlag      <= 1'b1;
         digitalMonitorOn <= 1'b1;
      end
      else if (clockEnable && state_reg == pors_pkg::ST_RESET && !anyReq && !porCycle_reg)
      begin
         powerOnFlag <= monCycle_reg;
         if (monCycle_reg)
            digitalMonitorOn <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstSync_reg)
   begin
      if (!rstSync_reg)
         porMonitorOn <= 1'b1;
      else if (clockEnable)
         porMonitorOn <= !por_monitor_disable_reg;
   end

   logic [3:0] wdogDiv_reg;
   always_ff @(posedge clock or negedge rstSync_reg)
   begin
      if (!rstSync_reg)
      begin
         ctl         <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, pors_pkg::PORT_LATCH_RESET,
                          pors_pkg::RESET_VECTOR, 1'b1, 1'b0};
         coreReset   <= 1'b1;
         resetPinLow <= 1'b1;
         resetPinOe  <= 1'b1;
         wdogDiv_reg <= 4'h0;
         wdogTick    <= 1'b0;
      end
      else if (clockEnable)
      begin
         ctl.cpuHalt          <= inReset;
         ctl.sfrInit          <= inReset;
         ctl.portsForce       <= inReset;
         ctl.irqTimerOff      <= inReset;
         ctl.pullupsOn        <= 1'b1;
         ctl.portLatch        <= pors_pkg::PORT_LATCH_RESET;
         ctl.pcValue          <= pors_pkg::RESET_VECTOR;
         ctl.clockSelInternal <= 1'b1;
         ctl.wdogEnable       <= !inReset;
         coreReset            <= inReset;
         resetPinLow          <= inReset && (porCycle_reg || monCycle_reg);
         resetPinOe           <= inReset && (porCycle_reg || monCycle_reg);
         if (inReset || wdogDiv_reg == 4'(pors_pkg::WDOG_DIVIDE - 1))
            wdogDiv_reg <= 4'h0;
         else
            wdogDiv_reg <= wdogDiv_reg + 4'h1;
         wdogTick <= !inReset && wdogDiv_reg == 4'(pors_pkg::WDOG_DIVIDE - 1);
      end
   end

   // ************************************
   // assertions
   // ************************************
   property p_haltInReset;
      @(posedge clock) disable iff (!rstSync_reg)
      clockEnable && state_reg == pors_pkg::ST_RESET |=> ctl.cpuHalt;
   endproperty
   a_haltInReset: assert property (p_haltInReset) else $error("cpu not halted");

   property p_latch;
      @(posedge clock) disable iff (!rstSync_reg)
      ctl.portLatch == pors_pkg::PORT_LATCH_RESET && ctl.pullupsOn;
   endproperty
   a_latch: assert property (p_latch) else $error("port latch wrong");

   property p_vector;
      @(posedge clock) disable iff (!rstSync_reg)
      ctl.pcValue == pors_pkg::RESET_VECTOR && ctl.clockSelInternal;
   endproperty
   a_vector: assert property (p_vector) else $error("vector wrong");

   property p_noDelay;
      @(posedge clock) disable iff (!rstSync_reg)
      clockEnable && state_reg == pors_pkg::ST_RESET && !anyReq && !porCycle_reg
      |=> state_reg == pors_pkg::ST_RUN;
   endproperty
   a_noDelay: assert property (p_noDelay) else $error("delay applied");

   property p_fullPor;
      @(posedge clock) disable iff (!rstSync_reg)
      clockEnable && state_reg == pors_pkg::ST_RUN && anyReq && por_monitor_disable_reg
      |=> porCycle_reg && !por_monitor_disable_reg;
   endproperty
   a_fullPor: assert property (p_fullPor) else $error("no full reset");

   property p_por_monitor_disable;
      @(posedge clock) disable iff (!rstSync_reg)
      clockEnable && state_reg == pors_pkg::ST_RUN && monDisWrite && !anyReq |=> por_monitor_disable_reg;
   endproperty
   a_por_monitor_disable: assert property (p_por_monitor_disable) else $error("monitor not disabled");

   property p_wdog;
      @(posedge clock) disable iff (!rstSync_reg)
      wdogTick && $past(wdogTick) |-> !$past(clockEnable);
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog tick too fast");

   property p_pin;
      @(posedge clock) disable iff (!rstSync_reg)
      clockEnable && state_reg == pors_pkg::ST_RESET && (porCycle_reg || monCycle_reg)
      |=> resetPinLow;
   endproperty
   a_pin: assert property (p_pin) else $error("reset pin not low");

   // reset exit without the power-on delay
   sequence s_resetExit;
      clockEnable && state_reg == pors_pkg::ST_RESET && !anyReq && !porCycle_reg;
   endsequence

   property p_failFlag;
      @(posedge clock) disable iff (!rstSync_reg)
      s_resetExit ##0 monCycle_reg |=> powerOnFlag && resetPinLow;
   endproperty
   a_failFlag: assert property (p_failFlag) else $error("power-fail flag not set");

   property p_otherClear;
      @(posedge clock) disable iff (!rstSync_reg)
      s_resetExit ##0 !monCycle_reg |=> !powerOnFlag && !resetPinLow;
   endproperty
   a_otherClear: assert property (p_otherClear) else $error("flag not cleared");

endmodule

// [pors_supply_model.sv]
module pors_supply_model (
   // commands from the bench
   input  wire logic                   reqCmd0,
   input  wire logic [4:0]             reqCmd,
   input  wire logic                   hsCmd,
   // comparator and reset pin levels
   output pors_pkg::pors_req_type      resetReq,
   output logic                        highSupply
);
   timeunit 1ns;
   timeprecision 1ps;
   // comparators settle a few ns after the supply moves
   assign #3 resetReq   = pors_pkg::pors_req_type'(reqCmd | {4'h0, reqCmd0});
   // 1 selects the long release delay
   assign #3 highSupply = hsCmd;
endmodule

// [test_power_on_reset_sequencer.sv]
module test_power_on_reset_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   clock, nrst, clockEnable, modeWrite, hsCmd;
   logic [7:0]             modeData;
   logic [4:0]             reqCmd;
   pors_pkg::pors_req_type resetReq;
   pors_pkg::pors_ctl_type ctl;
   logic                   highSupply, coreReset, resetPinLow, resetPinOe;
   logic                   powerOnFlag, porMonitorOn, digitalMonitorOn, wdogTick;
   int                     error_cnt = 0;
   int                     n_compared = 0;
   int                     expMon = 1;
   logic [31:0]            rnd = 32'h868A6EB2;

   pors_supply_model pors_supply_model_i (.reqCmd0(1'b0), .reqCmd(reqCmd), .hsCmd(hsCmd),
      .resetReq(resetReq), .highSupply(highSupply));
   pors_sequencer #(.DELAY_LOW(10), .DELAY_HIGH(20)) pors_sequencer_i (.clock(clock),
      .nrst(nrst), .clockEnable(clockEnable), .resetReq(resetReq), .highSupply(highSupply),
      .modeWrite(modeWrite), .modeData(modeData), .ctl(ctl), .coreReset(coreReset),
      .resetPinLow(resetPinLow), .resetPinOe(resetPinOe), .powerOnFlag(powerOnFlag),
      .porMonitorOn(porMonitorOn), .digitalMonitorOn(digitalMonitorOn), .wdogTick(wdogTick));

   // ************************************
   // helpers
   // ************************************
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task print_verdict;
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   function logic [31:0] next_rnd(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // ************************************
   // one reset cycle against the model
   // ************************************
   task do_reset(input logic [4:0] req, input logic hs, input int frz);
      int cnt, d, full, pin;
      full = req[4] || expMon == 0;
      pin = full || req[3];
      d = full ? (hs ? 20 : 10) : 0;
      hsCmd = hs;
      reqCmd = req;
      cnt = 0;
      while (coreReset !== 1'b1 && cnt < 20)
      begin
         step(1);
         cnt++;
      end
      check(coreReset, 1);
      check({ctl.cpuHalt, ctl.sfrInit, ctl.portsForce, ctl.irqTimerOff}, 4'hF);
      check({ctl.pullupsOn, ctl.portLatch}, 9'h1FF);
      check({resetPinLow, resetPinOe}, {2{pin[0]}});
      check({ctl.wdogEnable, ctl.clockSelInternal, ctl.pcValue}, 18'h10000);
      modeData = 8'h20;
      modeWrite = 1'b1;
      step(1);
      modeWrite = 1'b0;
      step(2);
      reqCmd = 5'h00;
      clockEnable = 1'b0;
      step(frz);
      clockEnable = 1'b1;
      cnt = 0;
      while (coreReset !== 1'b0 && cnt < 60)
      begin
         step(1);
         cnt++;
      end
      check(cnt, d + 4);
      if (full)
         expMon = 1;
      check(powerOnFlag, pin);
      check(porMonitorOn, expMon);
      if (pin)
         check(digitalMonitorOn, 1);
      check(ctl.pcValue, 16'h0000);
      check({ctl.clockSelInternal, ctl.wdogEnable, ctl.pullupsOn}, 3'h7);
      check({ctl.cpuHalt, ctl.sfrInit, ctl.portsForce, ctl.irqTimerOff, resetPinLow, resetPinOe},
            6'h00);
   endtask

   initial
   begin
      clock = 1'b0;
      forever
         #20 clock = ~clock;
   end

   initial
   begin
      #400000;
      error_cnt++;
      print_verdict;
   end

   initial
   begin
      int ticks;
      nrst = 1'b0;
      clockEnable = 1'b1;
      modeWrite = 1'b0;
      modeData = 8'h00;
      hsCmd = 1'b0;
      reqCmd = 5'h10;
      step(10);
      nrst = 1'b1;
      do_reset(5'h10, 1'b0, 0);
      ticks = 0;
      repeat (120)
      begin
         step(1);
         ticks += wdogTick;
      end
      check(ticks, 10);
      for (int i = 0; i < 16; i++)
      begin
         rnd = next_rnd(rnd);
         if (rnd[9])
         begin
            modeData = rnd[7:0] & 8'hDF;
            modeWrite = 1'b1;
            step(1);
            modeWrite = 1'b0;
            step(2);
            check(porMonitorOn, 1);
            modeData = rnd[7:0] | 8'h20;
            modeWrite = 1'b1;
            step(1);
            modeWrite = 1'b0;
            step(4);
            expMon = 0;
            check(porMonitorOn, 0);
         end
         do_reset(i < 5 ? 5'h01 << i : 5'h01 << (rnd[4:0] % 5), rnd[8], rnd[12:10]);
         step(3);
      end
      print_verdict;
   end
endmodule
